// ### verilog/msmc_pkg.sv
// Shared constants and types for the channel function button controller
package msmc_pkg;
    localparam int MSMC_NUM_CH = 16;
    localparam int MSMC_NUM_AUX = 4;
    // Solo-in-place button hold time before engaging
    localparam int MSMC_SIP_HOLD_MS = 1000;
    localparam int MSMC_CLK_HZ = 50000000;
    localparam int MSMC_SIP_HOLD_CYC = (MSMC_SIP_HOLD_MS * (MSMC_CLK_HZ / 1000));
    typedef enum logic [2:0] {
        MSMC_MODE_RET = 3'b001,
        MSMC_MODE_SOLO = 3'b010,
        MSMC_MODE_MUTE = 3'b100
    } msmc_mode_t;
    typedef enum logic [2:0] {
        MSMC_BUS_AFL = 3'b001,
        MSMC_BUS_PFL = 3'b010,
        MSMC_BUS_SIP = 3'b100
    } msmc_bus_t;
    localparam msmc_mode_t MSMC_MODE_RST = MSMC_MODE_SOLO;
    localparam msmc_bus_t MSMC_BUS_RST = MSMC_BUS_AFL;
    // Lamp colour codes
    localparam logic [1:0] MSMC_LAMP_OFF = 2'h0;
    localparam logic [1:0] MSMC_LAMP_ORANGE = 2'h1;
    localparam logic [1:0] MSMC_LAMP_YELLOW = 2'h2;
    localparam logic [1:0] MSMC_LAMP_RED = 2'h3;
endpackage

// ### verilog/msmc_ctrl.sv
// Channel function button, solo bus and talkback controller
// Notes on behaviour
// - In return mode a channel press toggles its playback return source.
// - Engaged playback return disconnects that channel's analog input from the mix.
// - In return mode, buttons of channels with return engaged light orange.
// - In solo mode, channel and aux presses toggle their solo state.
// - Soloed channels route to main or monitor outputs per solo-bus mode.
// - In solo mode, soloed channel or bus buttons light yellow.
// - Soloing a channel or bus selects it and lights its select button.
// - Solo-in-place solo mode: soloed yellow, other channels red unless manually unmuted; presses still solo.
// - In mute mode, channel and aux presses toggle muting to main and aux.
// - In mute mode, muted channel or bus buttons light red.
// - Solo bus has after-fader, pre-fader, solo-in-place modes; after-fader default.
// - After-fader listen taps soloed channels after the fader.
// - Pre-fader listen taps soloed channels before the fader.
// - Listen modes feed only the solo bus; main and aux mixes unchanged.
// - Aux bus solos always use the pre-fader tap.
// - After-fader tap is never offered for aux buses.
// - Solo-in-place mutes unsoloed input channels in mains while any input channel is soloed; aux buses excluded.
// - Solo-in-place muting applies to main bus only, not aux mixes.
// - Operator may manually unmute a channel during solo-in-place.
// - Solo-in-place engages only after a long hold; short press does not engage it.
// - Two talkback assign buttons toggle independently and light while assigned.
// - Talkback enable toggles on each press and lights while active.
module msmc_ctrl
    import msmc_pkg::*;
#(
    parameter int NUM_CH = MSMC_NUM_CH,
    parameter int NUM_AUX = MSMC_NUM_AUX,
    parameter int SIP_HOLD_CYC = MSMC_SIP_HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ret_mode_press,
    input wire logic solo_mode_press,
    input wire logic mute_mode_press,
    input wire logic [NUM_CH-1:0] ch_btn_press,
    input wire logic [NUM_AUX-1:0] aux_btn_press,
    input wire logic afl_press,
    input wire logic pfl_press,
    input wire logic sip_btn,
    input wire logic [NUM_CH-1:0] ch_unmute_press,
    input wire logic tb_assign12_press,
    input wire logic tb_assign34_press,
    input wire logic tb_enable_press,
    output logic [2:0] mode_lamp,
    output logic [2:0] bus_mode,
    output logic sip_lamp_red,
    output logic [2*NUM_CH-1:0] ch_lamp,
    output logic [2*NUM_AUX-1:0] aux_lamp,
    output logic [NUM_CH-1:0] ch_return_sel,
    output logic [NUM_CH-1:0] ch_analog_to_mix,
    output logic [NUM_CH-1:0] ch_main_mute,
    output logic [NUM_CH-1:0] ch_aux_mute,
    output logic [NUM_AUX-1:0] aux_mute,
    output logic [NUM_CH-1:0] ch_solo_pre,
    output logic [NUM_CH-1:0] ch_solo_post,
    output logic [NUM_AUX-1:0] aux_solo_pre,
    output logic [NUM_CH+NUM_AUX-1:0] select_lamp,
    output logic tb_assign12,
    output logic tb_assign34,
    output logic tb_enable
);
    localparam int NSRC = NUM_CH + NUM_AUX;
    localparam int HW = $clog2(SIP_HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_MAX = HW'(SIP_HOLD_CYC);

    msmc_mode_t mode_q, mode_d;
    msmc_bus_t bus_q, bus_d;
    logic [NUM_CH-1:0] ret_q;
    logic [NSRC-1:0] solo_q, mute_q, sel_q, sel_d;
    logic [NUM_CH-1:0] sip_unm_q;
    logic [HW-1:0] hold_q;
    logic sip_armed_q;
    logic tb12_q, tb34_q, tben_q;
    logic [2*NUM_CH-1:0] ch_lamp_d;
    logic [2*NUM_AUX-1:0] aux_lamp_d;
    wire [NSRC-1:0] src_press = {aux_btn_press, ch_btn_press};
    wire in_ret = (mode_q == MSMC_MODE_RET);
    wire in_solo = (mode_q == MSMC_MODE_SOLO);
    wire in_mute = (mode_q == MSMC_MODE_MUTE);
    wire sip_on = (bus_q == MSMC_BUS_SIP);
    wire [NUM_CH-1:0] ret_tog = in_ret ? ch_btn_press : '0;
    wire [NSRC-1:0] solo_tog = in_solo ? src_press : '0;
    wire [NSRC-1:0] mute_tog = in_mute ? src_press : '0;
    wire [NSRC-1:0] solo_n = solo_q ^ solo_tog;
    wire [NUM_CH-1:0] ch_solo = solo_q[NUM_CH-1:0];
    wire any_ch_solo = |ch_solo;
    wire hold_done = sip_btn && (hold_q == HOLD_MAX);

    always_comb begin
        mode_d = mode_q;
        if (ret_mode_press) begin
            mode_d = MSMC_MODE_RET;
        end else if (solo_mode_press) begin
            mode_d = MSMC_MODE_SOLO;
        end else if (mute_mode_press) begin
            mode_d = MSMC_MODE_MUTE;
        end
    end

    always_comb begin
        bus_d = bus_q;
        if (hold_done && !sip_armed_q) begin
            bus_d = MSMC_BUS_SIP;
        end else if (pfl_press) begin
            bus_d = MSMC_BUS_PFL;
        end else if (afl_press) begin
            bus_d = MSMC_BUS_AFL;
        end else if (sip_on && sip_btn && !sip_armed_q) begin
            // Short press while engaged leaves it
            bus_d = MSMC_BUS_AFL;
        end
    end

    always_comb begin
        sel_d = sel_q;
        for (int i = 0; i < NSRC; i++) begin
            if (solo_tog[i] && solo_n[i]) begin
                sel_d = '0;
                sel_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= MSMC_MODE_RST;
            bus_q <= MSMC_BUS_RST;
            ret_q <= '0;
            solo_q <= '0;
            mute_q <= '0;
            sel_q <= '0;
        end else begin
            mode_q <= mode_d;
            bus_q <= bus_d;
            ret_q <= ret_q ^ ret_tog;
            solo_q <= solo_n;
            mute_q <= mute_q ^ mute_tog;
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= '0;
            sip_armed_q <= 1'b0;
        end else begin
            hold_q <= !sip_btn ? '0 : (hold_done ? hold_q : hold_q + 1'b1);
            // Armed blocks retrigger until release
            sip_armed_q <= sip_btn && (sip_armed_q || hold_done || sip_on);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sip_unm_q <= '0;
        end else if (!sip_on) begin
            sip_unm_q <= '0;
        end else begin
            sip_unm_q <= sip_unm_q ^ ch_unmute_press;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tb12_q <= 1'b0;
            tb34_q <= 1'b0;
            tben_q <= 1'b0;
        end else begin
            tb12_q <= tb12_q ^ tb_assign12_press;
            tb34_q <= tb34_q ^ tb_assign34_press;
            tben_q <= tben_q ^ tb_enable_press;
        end
    end

    wire [NUM_CH-1:0] sip_mute = (sip_on && any_ch_solo) ? (~ch_solo & ~sip_unm_q) : '0;
    wire [NUM_CH-1:0] analog_n = ~ret_q;
    wire [NUM_CH-1:0] aux_mute_n = mute_q[NUM_CH-1:0];
    // listen modes leave main mix alone
    wire [NUM_CH-1:0] main_mute_n = mute_q[NUM_CH-1:0] | sip_mute;
    wire [NUM_CH-1:0] post_n = (bus_q == MSMC_BUS_AFL) ? ch_solo : '0;
    wire [NUM_CH-1:0] pre_n = (bus_q != MSMC_BUS_AFL) ? ch_solo : '0;

    function automatic logic [1:0] lamp_of(input logic r, input logic s, input logic m,
                                           input logic sipm);
        logic [1:0] c;
        c = MSMC_LAMP_OFF;
        if (in_ret && r) begin
            c = MSMC_LAMP_ORANGE;
        end else if (in_solo && s) begin
            c = MSMC_LAMP_YELLOW;
        end else if (in_solo && sipm) begin
            c = MSMC_LAMP_RED;
        end else if (in_mute && m) begin
            c = MSMC_LAMP_RED;
        end
        return c;
    endfunction

    always_comb begin
        ch_lamp_d = '0;
        aux_lamp_d = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            ch_lamp_d[2*i +: 2] = lamp_of(ret_q[i], solo_q[i], mute_q[i], sip_mute[i]);
        end
        for (int j = 0; j < NUM_AUX; j++) begin
            aux_lamp_d[2*j +: 2] = lamp_of(1'b0, solo_q[NUM_CH+j], mute_q[NUM_CH+j], 1'b0);
        end
    end

    // Registered outputs; one cycle behind the state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_lamp <= '0;
            bus_mode <= '0;
            sip_lamp_red <= 1'b0;
            ch_lamp <= '0;
            aux_lamp <= '0;
            ch_return_sel <= '0;
            ch_analog_to_mix <= '0;
            ch_main_mute <= '0;
            ch_aux_mute <= '0;
            aux_mute <= '0;
            ch_solo_pre <= '0;
            ch_solo_post <= '0;
            aux_solo_pre <= '0;
            select_lamp <= '0;
            tb_assign12 <= 1'b0;
            tb_assign34 <= 1'b0;
            tb_enable <= 1'b0;
        end else begin
            mode_lamp <= mode_q;
            bus_mode <= bus_q;
            sip_lamp_red <= sip_on;
            ch_lamp <= ch_lamp_d;
            aux_lamp <= aux_lamp_d;
            ch_return_sel <= ret_q;
            ch_analog_to_mix <= analog_n;
            ch_main_mute <= main_mute_n;
            ch_aux_mute <= aux_mute_n;
            aux_mute <= mute_q[NSRC-1:NUM_CH];
            ch_solo_pre <= pre_n;
            ch_solo_post <= post_n;
            // aux solos pre-fader, no post tap for aux
            aux_solo_pre <= solo_q[NSRC-1:NUM_CH];
            select_lamp <= sel_q;
            tb_assign12 <= tb12_q;
            tb_assign34 <= tb34_q;
            tb_enable <= tben_q;
        end
    end

    property p_return_blocks_analog;
        @(posedge clk) disable iff (!rst_b) ##1 (ch_return_sel & ch_analog_to_mix) == '0;
    endproperty
    a_return_blocks_analog: assert property (p_return_blocks_analog)
        else $error("return and analog both on");

    property p_ret_toggle;
        @(posedge clk) disable iff (!rst_b)
            (in_ret && ch_btn_press[0]) |=> (ret_q[0] != $past(ret_q[0]));
    endproperty
    a_ret_toggle: assert property (p_ret_toggle)
        else $error("return did not toggle");

    property p_one_mode;
        @(posedge clk) disable iff (!rst_b) $onehot(mode_q);
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("mode not one-hot");

    property p_short_no_sip;
        @(posedge clk) disable iff (!rst_b)
            (!sip_on && $rose(sip_btn)) ##1 !sip_btn |=> !sip_on;
    endproperty
    a_short_no_sip: assert property (p_short_no_sip)
        else $error("short press entered solo in place");

    property p_sip_aux_clean;
        @(posedge clk) disable iff (!rst_b) ch_aux_mute == $past(mute_q[NUM_CH-1:0]);
    endproperty
    a_sip_aux_clean: assert property (p_sip_aux_clean)
        else $error("aux mute follows solo in place");

    property p_solo_lamp;
        @(posedge clk) disable iff (!rst_b)
            (in_solo && solo_q[0]) |=> ch_lamp[1:0] == MSMC_LAMP_YELLOW;
    endproperty
    a_solo_lamp: assert property (p_solo_lamp)
        else $error("solo lamp not yellow");

    property p_solo_select;
        @(posedge clk) disable iff (!rst_b)
            (in_solo && ch_btn_press[0] && !solo_q[0] && ch_btn_press[NUM_CH-1:1] == '0
             && aux_btn_press == '0) |=> ##1 select_lamp[0];
    endproperty
    a_solo_select: assert property (p_solo_select)
        else $error("solo did not select");

    property p_default_afl;
        @(posedge clk) $rose(rst_b) |-> bus_q == MSMC_BUS_AFL;
    endproperty
    a_default_afl: assert property (p_default_afl)
        else $error("solo bus not after-fader at reset");

    property p_tb_toggle;
        @(posedge clk) disable iff (!rst_b)
            tb_enable_press |=> ##1 (tb_enable != $past(tb_enable));
    endproperty
    a_tb_toggle: assert property (p_tb_toggle)
        else $error("talkback did not toggle");

    c_sip: cover property (@(posedge clk) disable iff (!rst_b) $rose(sip_on));
    c_sip_mute: cover property (@(posedge clk) disable iff (!rst_b) sip_mute != '0);
    c_ret: cover property (@(posedge clk) disable iff (!rst_b) in_ret && ret_q != '0);
    c_tb_both: cover property (@(posedge clk) disable iff (!rst_b) tb12_q && tb34_q);
endmodule // msmc_ctrl

// ### tb/msmc_panel.sv
// Front panel model: operator buttons as one-cycle pulses and a held solo-in-place key
module msmc_panel #(
    parameter int NCH = 8,
    parameter int NAUX = 4
) (
    input wire logic clk,
    output logic [NCH-1:0] ch,
    output logic [NAUX-1:0] aux,
    output logic [NCH-1:0] unm,
    output logic [7:0] key,
    output logic solo_in_place
);
    timeunit 1ns;
    timeprecision 1ns;

    task automatic clr();
        ch = '0;
        aux = '0;
        unm = '0;
        key = '0;
    endtask

    initial begin
        clr();
        solo_in_place = 1'b0;
    end

    // Released keys fall back low, as on a pulled-down switch
    task automatic tap(input int k, input int i);
        @(negedge clk);
        if (k == 0) ch[i] = 1'b1;
        else if (k == 1) aux[i] = 1'b1;
        else if (k == 10) unm[i] = 1'b1;
        else key[k-2] = 1'b1;
        @(negedge clk);
        clr();
    endtask

    task automatic hold(input int n);
        @(negedge clk);
        solo_in_place = 1'b1;
        repeat (n) @(negedge clk);
        solo_in_place = 1'b0;
    endtask
endmodule // msmc_panel

// ### tb/test_msmc_ctrl.sv
// Self-checking bench for the channel function button controller
module test_msmc_ctrl
    import msmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 8;
    localparam int NAUX = 4;
    localparam int SIPH = 8;
    logic clk = 1'b0;
    logic rst_b;
    logic [NCH-1:0] ch, unm, e_ret, e_solo, e_mute, e_unm;
    logic [NAUX-1:0] aux, e_asolo, e_amute;
    logic [7:0] key;
    logic solo_in_place, e_t12, e_t34, e_ten;
    msmc_mode_t e_mode;
    msmc_bus_t e_bus;
    logic [2:0] mode_lamp, bus_mode;
    logic sip_lamp_red, tb_assign12, tb_assign34, tb_enable;
    logic [2*NCH-1:0] ch_lamp;
    logic [2*NAUX-1:0] aux_lamp;
    logic [NCH-1:0] ch_return_sel, ch_analog_to_mix, ch_main_mute, ch_aux_mute;
    logic [NCH-1:0] ch_solo_pre, ch_solo_post;
    logic [NAUX-1:0] aux_mute, aux_solo_pre;
    logic [NCH+NAUX-1:0] select_lamp;
    int n_mismatch = 0;
    int total_checks = 0;
    int n, r;

    always #10 clk = ~clk;

    msmc_panel #(.NCH(NCH), .NAUX(NAUX)) pnl (.clk(clk), .ch(ch), .aux(aux), .unm(unm),
        .key(key), .solo_in_place(solo_in_place));

    msmc_ctrl #(.NUM_CH(NCH), .NUM_AUX(NAUX), .SIP_HOLD_CYC(SIPH)) uut (.clk(clk),
        .rst_b(rst_b), .ret_mode_press(key[0]), .solo_mode_press(key[1]),
        .mute_mode_press(key[2]), .ch_btn_press(ch), .aux_btn_press(aux),
        .afl_press(key[3]), .pfl_press(key[4]), .sip_btn(solo_in_place), .ch_unmute_press(unm),
        .tb_assign12_press(key[5]), .tb_assign34_press(key[6]), .tb_enable_press(key[7]),
        .mode_lamp(mode_lamp), .bus_mode(bus_mode), .sip_lamp_red(sip_lamp_red),
        .ch_lamp(ch_lamp), .aux_lamp(aux_lamp), .ch_return_sel(ch_return_sel),
        .ch_analog_to_mix(ch_analog_to_mix), .ch_main_mute(ch_main_mute),
        .ch_aux_mute(ch_aux_mute), .aux_mute(aux_mute), .ch_solo_pre(ch_solo_pre),
        .ch_solo_post(ch_solo_post), .aux_solo_pre(aux_solo_pre),
        .select_lamp(select_lamp), .tb_assign12(tb_assign12),
        .tb_assign34(tb_assign34), .tb_enable(tb_enable));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        total_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Lamp colour follows the current mode only
    function automatic logic [1:0] lamp(input logic rt, input logic so, input logic sm,
        input logic mu);
        case (e_mode)
            MSMC_MODE_RET: lamp = rt ? MSMC_LAMP_ORANGE : MSMC_LAMP_OFF;
            MSMC_MODE_SOLO: lamp = so ? MSMC_LAMP_YELLOW : (sm ? MSMC_LAMP_RED : MSMC_LAMP_OFF);
            default: lamp = mu ? MSMC_LAMP_RED : MSMC_LAMP_OFF;
        endcase
    endfunction

    task automatic check_all();
        logic [NCH-1:0] sm, na;
        logic [2*NCH-1:0] el;
        logic [2*NAUX-1:0] ea;
        sm = (e_bus == MSMC_BUS_SIP && |e_solo) ? (~e_solo & ~e_unm) : '0;
        na = ~e_ret;
        for (int j = 0; j < NCH; j++) el[2*j+:2] = lamp(e_ret[j], e_solo[j], sm[j], e_mute[j]);
        for (int j = 0; j < NAUX; j++) ea[2*j+:2] = lamp(1'b0, e_asolo[j], 1'b0, e_amute[j]);
        chk("mode_lamp", e_mode, mode_lamp);
        chk("bus_mode", e_bus, bus_mode);
        chk("ch_lamp", el, ch_lamp);
        chk("aux_lamp", ea, aux_lamp);
        chk("ch_return_sel", e_ret, ch_return_sel);
        chk("ch_analog_to_mix", na, ch_analog_to_mix);
        chk("ch_main_mute", e_mute | sm, ch_main_mute);
        chk("ch_aux_mute", e_mute, ch_aux_mute);
        chk("aux_mute", e_amute, aux_mute);
        chk("ch_solo_post", e_bus == MSMC_BUS_AFL ? e_solo : '0, ch_solo_post);
        chk("ch_solo_pre", e_bus != MSMC_BUS_AFL ? e_solo : '0, ch_solo_pre);
        chk("aux_solo_pre", e_asolo, aux_solo_pre);
        chk("talkback", {e_t12, e_t34, e_ten}, {tb_assign12, tb_assign34, tb_enable});
    endtask

    // One press, then the model update and a compare of every output but sip_lamp_red once outputs settle; select_lamp only after a solo
    task automatic act(input int k, input int i);
        logic on;
        on = 1'b0;
        pnl.tap(k, i);
        case (k)
            0: if (e_mode == MSMC_MODE_RET) e_ret[i] ^= 1'b1;
               else if (e_mode == MSMC_MODE_SOLO) begin
                   e_solo[i] ^= 1'b1;
                   on = e_solo[i];
               end else e_mute[i] ^= 1'b1;
            1: if (e_mode == MSMC_MODE_SOLO) begin
                   e_asolo[i] ^= 1'b1;
                   on = e_asolo[i];
               end else if (e_mode == MSMC_MODE_MUTE) e_amute[i] ^= 1'b1;
            2: e_mode = MSMC_MODE_RET;
            3: e_mode = MSMC_MODE_SOLO;
            4: e_mode = MSMC_MODE_MUTE;
            5, 6: begin
                e_bus = (k == 5) ? MSMC_BUS_AFL : MSMC_BUS_PFL;
                e_unm = '0;
            end
            7: e_t12 ^= 1'b1;
            8: e_t34 ^= 1'b1;
            9: e_ten ^= 1'b1;
            default: if (e_bus == MSMC_BUS_SIP) e_unm[i] ^= 1'b1;
        endcase
        @(negedge clk);
        check_all();
        if (on) chk("select_lamp", 64'h1 << (k * NCH + i), select_lamp);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("FAIL watchdog expected done seen timeout");
        end_sim();
    end

    initial begin
        void'($urandom(23));
        rst_b = 1'b0;
        {e_ret, e_solo, e_mute, e_unm, e_asolo, e_amute, e_t12, e_t34, e_ten} = '0;
        e_mode = MSMC_MODE_RST;
        e_bus = MSMC_BUS_RST;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        check_all();
        act(0, 0);
        act(0, NCH - 1);
        act(1, NAUX - 1);
        act(6, 0);
        act(0, 0);
        act(10, 2);
        for (n = 0; n < 80; n++) begin
            r = $urandom_range(0, 9);
            if (r < 3) act($urandom_range(2, 6), 0);
            else if (r < 9) begin
                r = $urandom_range(0, NCH + NAUX - 1);
                if (r < NCH) act(0, r);
                else act(1, r - NCH);
            end else act($urandom_range(7, 9), 0);
        end
        act(3, 0);
        if (!e_solo[1]) act(0, 1);
        pnl.hold(1);
        pnl.hold(4);
        repeat (2) @(negedge clk);
        check_all();
        pnl.hold(SIPH + 3);
        e_bus = MSMC_BUS_SIP;
        repeat (2) @(negedge clk);
        check_all();
        chk("sip_lamp_red", 1'b1, sip_lamp_red);
        act(1, 0);
        act(0, 5);
        act(10, 3);
        act(4, 0);
        act(0, 3);
        act(3, 0);
        // Short press while engaged drops back to after-fader listen
        pnl.hold(1);
        e_bus = MSMC_BUS_AFL;
        e_unm = '0;
        repeat (2) @(negedge clk);
        check_all();
        act(6, 0);
        @(negedge clk);
        chk("sip_lamp_red", 1'b0, sip_lamp_red);
        end_sim();
    end
endmodule // test_msmc_ctrl
